// *** rtl/uart_pkg.sv ***
// Constants, register map and state types for the UART core
package uart_pkg;

    // ----------------------------------------
    // Register offsets
    // ----------------------------------------
    localparam logic [2:0] ADDR_CTRL = 3'h0;
    localparam logic [2:0] ADDR_MODE = 3'h1;
    localparam logic [2:0] ADDR_STAT = 3'h2;
    localparam logic [2:0] ADDR_DIVL = 3'h3;
    localparam logic [2:0] ADDR_DIVH = 3'h4;
    localparam logic [2:0] ADDR_TXBUF = 3'h5;
    localparam logic [2:0] ADDR_RXBUF = 3'h6;

    // ----------------------------------------
    // Field positions
    // ----------------------------------------
    // Control register
    localparam int C_SWRST = 0;
    localparam int C_SYNC = 1;
    localparam int C_MSB = 2;
    localparam int C_SEVEN = 3;
    localparam int C_PEN = 4;
    localparam int C_PEVEN = 5;
    localparam int C_SPB = 6;
    localparam int C_DORM = 7;
    // Mode register, protocol field in bits 1:0
    localparam int M_MODE = 0;
    localparam int M_TXADDR = 2;
    localparam int M_RXEIE = 3;
    localparam int M_RXIE = 4;
    localparam int M_TXIE = 5;
    localparam int M_STTIE = 6;
    localparam int M_TXCPTIE = 7;
    // Status register
    localparam int S_RXF = 0;
    localparam int S_TXE = 1;
    localparam int S_IDLE = 2;
    localparam int S_PE = 3;
    localparam int S_FE = 4;
    localparam int S_OE = 5;
    localparam int S_RXERR = 6;
    localparam int S_TXCPT = 7;

    // ----------------------------------------
    // Reset values and timing
    // ----------------------------------------
    localparam logic [7:0] CTRL_RESET = 8'h01;
    localparam logic [7:0] MODE_RESET = 8'h00;
    localparam int CLK_HZ = 25000000;
    localparam int BAUD_DEFAULT = 115200;
    localparam logic [15:0] DIV_RESET = 16'(CLK_HZ / BAUD_DEFAULT);
    localparam logic [1:0] MODE_IDLE_LINE = 2'b01;
    localparam logic [3:0] IDLE_RX_BITS = 4'ha;
    localparam logic [3:0] IDLE_TX_BITS = 4'hb;

    // ----------------------------------------
    // State machines
    // ----------------------------------------
    typedef enum logic [2:0] {
        RX_OFF = 3'b001,
        RX_FRAME = 3'b010,
        RX_GAP = 3'b100
    } rx_state_e;

    typedef enum logic [2:0] {
        TX_IDLE = 3'b001,
        TX_GAP = 3'b010,
        TX_FRAME = 3'b100
    } tx_state_e;

endpackage

// *** rtl/uart_idle_line_multiproc.sv ***
// UART core with idle-line multiprocessor protocol
//
// How it works
// - Serial operation only while the sync mode select bit is zero.
// - Reset sets the soft reset bit; software may also set it.
// - Soft reset sets tx empty, clears rx/tx interrupt enables, receive and error flags.
// - Normal operation resumes only once the soft reset bit is cleared.
// - Frame is start, 7/8 data, optional parity, one or two stops.
// - Bit order select chooses MSB first, else LSB first.
// - Transmit and receive share one baud divisor.
// - Protocol field value 01 selects idle-line multiprocessor mode.
// - Ten or more marks after the stops raise the idle flag.
// - Receive bit timer stops after idle, restarts on a start edge.
// - First character after idle is an address, tagged by idle flag.
// - Dormant drops non-address characters without buffer or interrupt.
// - Dormant address loads buffer, sets flag, errors if enabled.
// - Address with errors is discarded while error enable is zero.
// - Hardware never changes the dormant bit; software clears it.
// - Clearing dormant mid-character flags that character at its end.
// - Address request is buffered; such a character follows 11 idle bits.
// - Address request clears when the start bit goes out.
// - Separate shift registers and buffers for each direction.
// - Receive start edge raises a wake-up request.
// - Separate event outputs for receive, transmit, start, done.
`timescale 1ns/100ps
module uart_idle_line_multiproc #(
    parameter logic [15:0] DIV_RESET = uart_pkg::DIV_RESET
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Register port
    input wire logic [2:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr_stb,
    input wire logic rd_stb,
    output logic [7:0] rdata,
    // Serial pins
    input wire logic serial_rx_pin,
    output logic serial_tx_pin,
    // Event outputs
    output logic rx_irq,
    output logic tx_irq,
    output logic start_irq,
    output logic tx_done_irq,
    output logic wake_req
);

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    // Map data bits to or from wire order
    function automatic logic [7:0] reorder(input logic [7:0] d,
                                           input logic msb,
                                           input logic [3:0] nd);
        logic [7:0] r;
        r = 8'h00;
        for (int i = 0; i < 8; i++) begin
            if (4'(i) < nd) begin
                r[i] = msb ? d[3'(nd - 4'(i) - 4'h1)] : d[i];
            end
        end
        return r;
    endfunction

    // Parity bit over the data bits
    function automatic logic parity(input logic [7:0] d,
                                    input logic even);
        return (^d) ^ ~even;
    endfunction

    // Sticky flag with set winning over clear
    function automatic logic upd(input logic q, input logic set,
                                 input logic clr);
        return set | (q & ~clr);
    endfunction

    // ----------------------------------------
    // State
    // ----------------------------------------
    logic [7:0] ctrl_q, mode_q, mode_d;
    logic [15:0] div_q;
    logic rx_flag_q, txe_q, idle_q, pe_q, fe_q, oe_q, txcpt_q;
    logic rx_s1_q, rx_s2_q, rx_s3_q, rx_lvl_q;
    uart_pkg::rx_state_e rx_st_q;
    logic [15:0] rx_cnt_q;
    logic [3:0] rx_bit_q, rx_gap_q;
    logic [11:0] rx_raw_q, rx_raw_d;
    logic idle_pend_q;
    logic [7:0] rxbuf_q, txbuf_q;
    logic txbuf_full_q, txbuf_addr_q;
    uart_pkg::tx_state_e tx_st_q;
    logic [15:0] tx_cnt_q;
    logic [3:0] tx_bit_q;
    logic [11:0] tx_sh_q, tx_frame;

    // ----------------------------------------
    // Decode
    // ----------------------------------------
    wire wr_ctrl = wr_stb && addr == uart_pkg::ADDR_CTRL;
    wire wr_mode = wr_stb && addr == uart_pkg::ADDR_MODE;
    wire wr_stat = wr_stb && addr == uart_pkg::ADDR_STAT;
    wire wr_divl = wr_stb && addr == uart_pkg::ADDR_DIVL;
    wire wr_divh = wr_stb && addr == uart_pkg::ADDR_DIVH;
    wire wr_txb = wr_stb && addr == uart_pkg::ADDR_TXBUF;
    wire rd_rxb = rd_stb && addr == uart_pkg::ADDR_RXBUF;
    wire swrst = ctrl_q[uart_pkg::C_SWRST];
    wire hold = swrst | ctrl_q[uart_pkg::C_SYNC];
    wire msb = ctrl_q[uart_pkg::C_MSB];
    wire pen = ctrl_q[uart_pkg::C_PEN];
    wire even = ctrl_q[uart_pkg::C_PEVEN];
    wire spb = ctrl_q[uart_pkg::C_SPB];
    wire dormant = ctrl_q[uart_pkg::C_DORM];
    wire rxeie = mode_q[uart_pkg::M_RXEIE];
    wire idle_mode = mode_q[1:0] == uart_pkg::MODE_IDLE_LINE;
    wire [7:0] clr = wr_stat ? wdata : 8'h00;

    // Frame geometry, shared by both directions
    wire [3:0] nd = ctrl_q[uart_pkg::C_SEVEN] ? 4'h7 : 4'h8;
    wire [3:0] par_pos = nd + 4'h1;
    wire [3:0] stop_pos = par_pos + {3'h0, pen};
    wire [3:0] last_bit = stop_pos + {3'h0, spb};
    wire [15:0] div_m1 = div_q - 16'h0001;

    // ----------------------------------------
    // Receive decode
    // ----------------------------------------
    // Line level changes once stages two and three agree
    wire rx_lvl_d = (rx_s2_q == rx_s3_q) ? rx_s3_q : rx_lvl_q;
    wire rx_fall = rx_lvl_q & ~rx_lvl_d;
    wire rx_start = rx_fall && !hold && rx_st_q != uart_pkg::RX_FRAME;
    wire rx_tick = rx_cnt_q == 16'h0000;
    wire rx_smp = rx_st_q == uart_pkg::RX_FRAME && rx_tick;
    wire rx_false = rx_smp && rx_bit_q == 4'h0 && rx_lvl_q;
    wire rx_done = rx_smp && rx_bit_q == last_bit && !hold;
    wire gap_tick = rx_st_q == uart_pkg::RX_GAP && rx_tick && !rx_fall;
    wire idle_det = gap_tick && rx_lvl_q
        && rx_gap_q == uart_pkg::IDLE_RX_BITS - 4'h1;

    // Raw frame including the bit sampled now
    always_comb begin
        rx_raw_d = rx_raw_q;
        if (rx_smp) begin
            rx_raw_d[rx_bit_q] = rx_lvl_q;
        end
    end

    // Character check and acceptance
    wire [7:0] rx_data = reorder(rx_raw_d[8:1], msb, nd);
    wire rx_pe = pen && rx_raw_d[par_pos] != parity(rx_data, even);
    wire rx_fe = ~rx_raw_d[stop_pos] | (spb & ~rx_raw_d[last_bit]);
    wire rx_err = rx_pe | rx_fe;
    wire is_addr = idle_mode & idle_pend_q;
    wire rx_accept = rx_done && (!dormant || is_addr)
        && (!rx_err || rxeie);
    wire err_set = rx_accept & rxeie;

    // ----------------------------------------
    // Transmit decode
    // ----------------------------------------
    wire tx_tick = tx_cnt_q == 16'h0000;
    wire tx_load = tx_st_q == uart_pkg::TX_IDLE && txbuf_full_q && !hold;
    wire tx_gap = txbuf_addr_q & idle_mode;
    wire gap_end = tx_st_q == uart_pkg::TX_GAP && tx_tick
        && tx_bit_q == uart_pkg::IDLE_TX_BITS - 4'h1;
    wire tx_start = (tx_load && !tx_gap) || gap_end;
    wire tx_end = tx_st_q == uart_pkg::TX_FRAME && tx_tick
        && tx_bit_q == last_bit;
    wire [7:0] tx_data = ctrl_q[uart_pkg::C_SEVEN]
        ? {1'b0, txbuf_q[6:0]} : txbuf_q;
    wire [7:0] tx_ord = reorder(txbuf_q, msb, nd);

    // Build the outgoing frame, start bit in bit 0
    always_comb begin
        tx_frame = 12'hfff;
        tx_frame[0] = 1'b0;
        for (int i = 0; i < 8; i++) begin
            if (4'(i) < nd) begin
                tx_frame[i + 1] = tx_ord[i];
            end
        end
        if (pen) begin
            tx_frame[par_pos] = parity(tx_data, even);
        end
    end

    // ----------------------------------------
    // Register access
    // ----------------------------------------
    wire rx_errst = pe_q | fe_q | oe_q;
    wire [7:0] stat = {txcpt_q, rx_errst, oe_q, fe_q, pe_q, idle_q,
                       txe_q, rx_flag_q};
    wire [7:0] rd_mux =
        addr == uart_pkg::ADDR_CTRL ? ctrl_q :
        addr == uart_pkg::ADDR_MODE ? mode_q :
        addr == uart_pkg::ADDR_STAT ? stat :
        addr == uart_pkg::ADDR_DIVL ? div_q[7:0] :
        addr == uart_pkg::ADDR_DIVH ? div_q[15:8] :
        addr == uart_pkg::ADDR_RXBUF ? rxbuf_q : 8'h00;

    // Mode: software write, request clear at start, rx/tx interrupt enables off in reset
    always_comb begin
        mode_d = wr_mode ? wdata : mode_q;
        if (tx_start && !wr_mode) begin
            mode_d[uart_pkg::M_TXADDR] = 1'b0;
        end
        if (swrst) begin
            mode_d[uart_pkg::M_RXIE] = 1'b0;
            mode_d[uart_pkg::M_TXIE] = 1'b0;
        end
    end

    // Configuration registers; dormant is only ever software written
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ctrl_q <= uart_pkg::CTRL_RESET;
            mode_q <= uart_pkg::MODE_RESET;
            div_q <= DIV_RESET;
        end else begin
            ctrl_q <= wr_ctrl ? wdata : ctrl_q;
            mode_q <= mode_d;
            div_q[7:0] <= wr_divl ? wdata : div_q[7:0];
            div_q[15:8] <= wr_divh ? wdata : div_q[15:8];
        end
    end

    // Status flags, write one to clear except tx empty, hardware set wins
    always_ff @(posedge clk) begin
        if (!rst_n || swrst) begin
            rx_flag_q <= 1'b0;
            pe_q <= 1'b0;
            fe_q <= 1'b0;
            oe_q <= 1'b0;
            txe_q <= 1'b1;
            idle_q <= 1'b0;
            txcpt_q <= 1'b0;
        end else begin
            rx_flag_q <= upd(rx_flag_q, rx_accept,
                             clr[uart_pkg::S_RXF] | rd_rxb);
            pe_q <= upd(pe_q, err_set & rx_pe, clr[uart_pkg::S_PE]);
            fe_q <= upd(fe_q, err_set & rx_fe, clr[uart_pkg::S_FE]);
            oe_q <= upd(oe_q, rx_accept & rx_flag_q, clr[uart_pkg::S_OE]);
            txe_q <= tx_load | (txe_q & ~wr_txb);
            idle_q <= upd(idle_q, (idle_det & idle_mode)
                          | (rx_accept & is_addr),
                          clr[uart_pkg::S_IDLE]);
            txcpt_q <= upd(txcpt_q, tx_end & ~txbuf_full_q,
                           clr[uart_pkg::S_TXCPT] | wr_txb);
        end
    end

    // Read data stands in the cycle after the strobe only
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rdata <= 8'h00;
        end else begin
            rdata <= rd_stb ? rd_mux : 8'h00;
        end
    end

    // ----------------------------------------
    // Receiver
    // ----------------------------------------
    // Pin synchroniser, three stages
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rx_s1_q <= 1'b1;
            rx_s2_q <= 1'b1;
            rx_s3_q <= 1'b1;
            rx_lvl_q <= 1'b1;
        end else begin
            rx_s1_q <= serial_rx_pin;
            rx_s2_q <= rx_s1_q;
            rx_s3_q <= rx_s2_q;
            rx_lvl_q <= rx_lvl_d;
        end
    end

    // Receive bit timer and frame sequencer
    always_ff @(posedge clk) begin
        if (!rst_n || hold) begin
            rx_st_q <= uart_pkg::RX_OFF;
            rx_cnt_q <= 16'h0000;
            rx_bit_q <= 4'h0;
            rx_gap_q <= 4'h0;
            rx_raw_q <= 12'h000;
            idle_pend_q <= 1'b0;
        end else if (rx_start) begin
            rx_st_q <= uart_pkg::RX_FRAME;
            rx_cnt_q <= {1'b0, div_q[15:1]};
            rx_bit_q <= 4'h0;
        end else begin
            rx_cnt_q <= rx_tick ? div_m1 : rx_cnt_q - 16'h0001;
            rx_raw_q <= rx_raw_d;
            unique case (rx_st_q)
                uart_pkg::RX_OFF: begin
                    rx_cnt_q <= 16'h0000;
                end
                uart_pkg::RX_FRAME: begin
                    if (rx_false) begin
                        rx_st_q <= uart_pkg::RX_OFF;
                        rx_cnt_q <= 16'h0000;
                    end else if (rx_done) begin
                        rx_st_q <= uart_pkg::RX_GAP;
                        rx_gap_q <= 4'h0;
                        idle_pend_q <= 1'b0;
                    end else if (rx_tick) begin
                        rx_bit_q <= rx_bit_q + 4'h1;
                    end
                end
                uart_pkg::RX_GAP: begin
                    if (idle_det) begin
                        rx_st_q <= uart_pkg::RX_OFF;
                        rx_cnt_q <= 16'h0000;
                        idle_pend_q <= 1'b1;
                    end else if (gap_tick) begin
                        rx_gap_q <= rx_lvl_q ? rx_gap_q + 4'h1 : 4'h0;
                    end
                end
                default: begin
                    rx_st_q <= uart_pkg::RX_OFF;
                end
            endcase
        end
    end

    // Receive buffer, separate from the shift path
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rxbuf_q <= 8'h00;
        end else if (rx_accept) begin
            rxbuf_q <= rx_data;
        end
    end

    // ----------------------------------------
    // Transmitter
    // ----------------------------------------
    // Transmit buffer with its buffered address request
    always_ff @(posedge clk) begin
        if (!rst_n || hold) begin
            txbuf_q <= 8'h00;
            txbuf_full_q <= 1'b0;
            txbuf_addr_q <= 1'b0;
        end else if (wr_txb) begin
            txbuf_q <= wdata;
            txbuf_full_q <= 1'b1;
            txbuf_addr_q <= mode_q[uart_pkg::M_TXADDR];
        end else if (tx_load) begin
            txbuf_full_q <= 1'b0;
        end
    end

    // Transmit sequencer: optional idle gap, then the frame
    always_ff @(posedge clk) begin
        if (!rst_n || hold) begin
            tx_st_q <= uart_pkg::TX_IDLE;
            tx_cnt_q <= 16'h0000;
            tx_bit_q <= 4'h0;
            tx_sh_q <= 12'hfff;
            serial_tx_pin <= 1'b1;
        end else begin
            tx_cnt_q <= tx_tick ? div_m1 : tx_cnt_q - 16'h0001;
            serial_tx_pin <= (tx_st_q == uart_pkg::TX_FRAME)
                ? tx_sh_q[tx_bit_q] : 1'b1;
            unique case (tx_st_q)
                uart_pkg::TX_IDLE: begin
                    tx_cnt_q <= div_m1;
                    tx_bit_q <= 4'h0;
                    if (tx_load) begin
                        tx_sh_q <= tx_frame;
                        tx_st_q <= tx_gap ? uart_pkg::TX_GAP
                                          : uart_pkg::TX_FRAME;
                    end
                end
                uart_pkg::TX_GAP: begin
                    if (gap_end) begin
                        tx_st_q <= uart_pkg::TX_FRAME;
                        tx_bit_q <= 4'h0;
                    end else if (tx_tick) begin
                        tx_bit_q <= tx_bit_q + 4'h1;
                    end
                end
                uart_pkg::TX_FRAME: begin
                    if (tx_end) begin
                        tx_st_q <= uart_pkg::TX_IDLE;
                    end else if (tx_tick) begin
                        tx_bit_q <= tx_bit_q + 4'h1;
                    end
                end
                default: begin
                    tx_st_q <= uart_pkg::TX_IDLE;
                end
            endcase
        end
    end

    // ----------------------------------------
    // Event outputs
    // ----------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rx_irq <= 1'b0;
            tx_irq <= 1'b0;
            start_irq <= 1'b0;
            tx_done_irq <= 1'b0;
            wake_req <= 1'b0;
        end else begin
            rx_irq <= rx_flag_q & mode_q[uart_pkg::M_RXIE];
            tx_irq <= txe_q & mode_q[uart_pkg::M_TXIE];
            start_irq <= rx_start & mode_q[uart_pkg::M_STTIE];
            tx_done_irq <= txcpt_q & mode_q[uart_pkg::M_TXCPTIE];
            wake_req <= rx_start;
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    sequence gap_done_s;
        tx_st_q == uart_pkg::TX_GAP && gap_end;
    endsequence
    sequence start_out_s;
        tx_st_q == uart_pkg::TX_FRAME ##1 !serial_tx_pin;
    endsequence

    reset_bit_a: assert property ($rose(rst_n) |-> swrst)
        else $error("soft reset bit not set after reset");
    swrst_flags_a: assert property (swrst |=>
        txe_q && !rx_flag_q && !pe_q && !fe_q && !oe_q
        && !mode_q[uart_pkg::M_RXIE] && !mode_q[uart_pkg::M_TXIE])
        else $error("flags not forced during soft reset");
    swrst_idle_a: assert property ($past(swrst) && swrst |->
        rx_st_q == uart_pkg::RX_OFF && tx_st_q == uart_pkg::TX_IDLE)
        else $error("link active during soft reset");
    sync_off_a: assert property (ctrl_q[uart_pkg::C_SYNC] |=>
        tx_st_q == uart_pkg::TX_IDLE ##1 serial_tx_pin)
        else $error("transmitter runs in sync mode");
    dormant_drop_a: assert property (rx_done && dormant
        && !is_addr |=> $stable(rxbuf_q) && !$rose(rx_flag_q))
        else $error("dormant data character accepted");
    addr_err_a: assert property (rx_done && rx_err && !rxeie
        |=> $stable(rxbuf_q) && !$rose(rx_flag_q))
        else $error("errored character accepted");
    accept_load_a: assert property (rx_done && !dormant
        && !rx_err |=> rx_flag_q && rxbuf_q == $past(rx_data))
        else $error("character not loaded");
    false_start_a: assert property (rx_false && !hold
        |=> rx_st_q == uart_pkg::RX_OFF && rx_cnt_q == 16'h0000)
        else $error("false start not rejected");
    idle_stop_a: assert property (idle_det && !hold && idle_mode
        |=> rx_st_q == uart_pkg::RX_OFF && idle_q && rx_cnt_q == 16'h0000)
        else $error("idle not flagged or timer running");
    gap_frame_a: assert property (gap_done_s |=> start_out_s)
        else $error("idle gap not followed by start bit");
    gap_mark_a: assert property (tx_st_q == uart_pkg::TX_GAP &&
        $past(tx_st_q) == uart_pkg::TX_GAP |-> serial_tx_pin)
        else $error("line not marking during idle gap");
    addr_clear_a: assert property (tx_start && !wr_mode
        |=> !mode_q[uart_pkg::M_TXADDR])
        else $error("address request not cleared at start");

endmodule

// *** dv/serial_node.sv ***
// Far-end serial node: sends and receives 8-bit characters
`timescale 1ns/100ps
module serial_node #(
    parameter int DIV = 8
) (
    // Clock and lines
    input wire logic clk,
    input wire logic rx_line,
    output logic tx_line
);
    initial tx_line = 1'b1;
    // Gap of marks, start, data LSB first, one stop
    task automatic send(input logic [7:0] d, input int gap, input logic sb);
        logic [9:0] f;
        f = {sb, d, 1'b0};
        repeat (gap * DIV) @(posedge clk);
        for (int i = 0; i < 10; i++) begin
            tx_line <= f[i];
            repeat (DIV) @(posedge clk);
        end
        tx_line <= 1'b1;
    endtask
    // Mid-bit sampling; unknown data on timeout
    task automatic recv(output logic [7:0] d, input int lim);
        logic ok;
        ok = 1'b0;
        d = 'x;
        for (int n = 0; n < lim && !ok; n++) begin
            @(posedge clk);
            ok = (rx_line === 1'b0);
        end
        if (!ok)
            return;
        repeat (DIV / 2) @(posedge clk);
        for (int i = 0; i < 8; i++) begin
            repeat (DIV) @(posedge clk);
            d[i] = rx_line;
        end
    endtask
endmodule

// *** dv/tb_uart_idle_line_multiproc.sv ***
// Self-checking bench for the UART core
`timescale 1ns/100ps
module tb_uart_idle_line_multiproc;
    localparam int D = 8;
    logic clk, rst_n, wr_stb, rd_stb, rx, tx, rx_irq, tx_irq, st_irq, dn_irq;
    logic wake;
    logic [2:0] addr;
    logic [7:0] wdata, rdata, d;
    int failures, check_count, wakes, sts, n;
    // Reset view: address beside expected read value
    logic [10:0] rows [8] = '{11'h001, 11'h100, 11'h202, 11'h308,
                              11'h400, 11'h500, 11'h600, 11'h700};
    uart_idle_line_multiproc #(.DIV_RESET(16'h0008))
        uart_idle_line_multiproc_inst (.clk(clk), .rst_n(rst_n),
        .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb),
        .rdata(rdata), .serial_rx_pin(rx), .serial_tx_pin(tx),
        .rx_irq(rx_irq), .tx_irq(tx_irq), .start_irq(st_irq),
        .tx_done_irq(dn_irq), .wake_req(wake));
    serial_node #(.DIV(D)) serial_node_inst (.clk(clk), .rx_line(tx),
        .tx_line(rx));
    // -----------------------------
    // Helpers
    // -----------------------------
    task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] v);
        @(posedge clk);
        wr_stb <= 1'b1;
        addr <= a;
        wdata <= v;
        @(posedge clk);
        wr_stb <= 1'b0;
    endtask
    task automatic rd(input logic [2:0] a, input logic [7:0] v);
        @(posedge clk);
        rd_stb <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd_stb <= 1'b0;
        #1 cmp(rdata, v);
    endtask
    task automatic final_report();
        $display("failures=%0d check_count=%0d", failures, check_count);
        if (failures == 0 && check_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // Clock, watchdog and start-edge counter
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    initial begin
        repeat (60000) @(posedge clk);
        failures++;
        final_report();
    end
    always @(posedge clk) begin
        if (wake === 1'b1) wakes++;
        if (st_irq === 1'b1) sts++;
    end
    // Main sequence
    initial begin
        rst_n = 1'b0;
        {wr_stb, rd_stb, addr, wdata, failures, check_count, wakes, sts} = '0;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        foreach (rows[i]) rd(rows[i][10:8], rows[i][7:0]);
        wr(uart_pkg::ADDR_TXBUF, 8'h5a);
        rd(uart_pkg::ADDR_STAT, 8'h02);
        wr(uart_pkg::ADDR_MODE, 8'h01);
        wr(uart_pkg::ADDR_CTRL, 8'h00);
        fork
            serial_node_inst.recv(d, 400);
            wr(uart_pkg::ADDR_TXBUF, 8'ha5);
        join
        cmp(d, 8'ha5);
        wr(uart_pkg::ADDR_CTRL, 8'h05);
        wr(uart_pkg::ADDR_CTRL, 8'h04);
        fork
            serial_node_inst.recv(d, 400);
            wr(uart_pkg::ADDR_TXBUF, 8'h31);
        join
        cmp(d, 8'h8c);
        wr(uart_pkg::ADDR_CTRL, 8'h79);
        wr(uart_pkg::ADDR_CTRL, 8'h78);
        fork
            serial_node_inst.recv(d, 400);
            wr(uart_pkg::ADDR_TXBUF, 8'h13);
        join
        cmp(d, 8'h93);
        wr(uart_pkg::ADDR_CTRL, 8'h01);
        wr(uart_pkg::ADDR_MODE, 8'h05);
        wr(uart_pkg::ADDR_CTRL, 8'h00);
        wr(uart_pkg::ADDR_TXBUF, 8'h42);
        n = 0;
        while (tx !== 1'b0 && n < 400) begin
            @(posedge clk);
            #1 n++;
        end
        cmp(8'(n >= 11 * D && n <= 11 * D + 4), 8'h01);
        rd(uart_pkg::ADDR_MODE, 8'h01);
        serial_node_inst.send(8'h11, 12, 1'b1);
        rd(uart_pkg::ADDR_RXBUF, 8'h11);
        wr(uart_pkg::ADDR_STAT, 8'hff);
        wr(uart_pkg::ADDR_CTRL, 8'h80);
        serial_node_inst.send(8'h3c, 12, 1'b1);
        rd(uart_pkg::ADDR_STAT, 8'h07);
        rd(uart_pkg::ADDR_RXBUF, 8'h3c);
        wr(uart_pkg::ADDR_STAT, 8'h04);
        serial_node_inst.send(8'h77, 1, 1'b1);
        rd(uart_pkg::ADDR_STAT, 8'h02);
        serial_node_inst.send(8'h55, 12, 1'b0);
        rd(uart_pkg::ADDR_STAT, 8'h06);
        rd(uart_pkg::ADDR_CTRL, 8'h80);
        wr(uart_pkg::ADDR_MODE, 8'hf9);
        // Dormant cleared in the middle of a data character
        fork
            serial_node_inst.send(8'h66, 1, 1'b1);
            begin
                repeat (40) @(posedge clk);
                wr(uart_pkg::ADDR_CTRL, 8'h00);
            end
        join
        rd(uart_pkg::ADDR_STAT, 8'h07);
        cmp(8'(rx_irq), 8'h01);
        rd(uart_pkg::ADDR_RXBUF, 8'h66);
        // Bad stop bit with the error enable on
        serial_node_inst.send(8'h0f, 1, 1'b0);
        rd(uart_pkg::ADDR_STAT, 8'h57);
        rd(uart_pkg::ADDR_RXBUF, 8'h0f);
        cmp(8'(wakes), 8'h06);
        cmp(8'(sts), 8'h02);
        repeat (3) @(posedge clk);
        cmp(8'(tx_irq), 8'h01);
        fork
            serial_node_inst.recv(d, 400);
            wr(uart_pkg::ADDR_TXBUF, 8'h3a);
        join
        cmp(d, 8'h3a);
        repeat (20) @(posedge clk);
        cmp(8'(dn_irq), 8'h01);
        wr(uart_pkg::ADDR_CTRL, 8'h81);
        rd(uart_pkg::ADDR_MODE, 8'hc9);
        rd(uart_pkg::ADDR_STAT, 8'h02);
        // Sync mode selected: the link stays held
        wr(uart_pkg::ADDR_CTRL, 8'h03);
        wr(uart_pkg::ADDR_CTRL, 8'h02);
        wr(uart_pkg::ADDR_TXBUF, 8'h00);
        repeat (12) @(posedge clk);
        cmp(8'(tx), 8'h01);
        final_report();
    end
endmodule
